// *** design/sac_pkg.sv ***
// ==========================================================
// converter control constants
package sac_pkg;

  // special register addresses
  localparam logic [7:0] SAC_ADDR_TRACK   = 8'hBA;
  localparam logic [7:0] SAC_ADDR_MUX     = 8'hBB;
  localparam logic [7:0] SAC_ADDR_CFG     = 8'hBC;
  localparam logic [7:0] SAC_ADDR_RES_LO  = 8'hBD;
  localparam logic [7:0] SAC_ADDR_RES_HI  = 8'hBE;
  localparam logic [7:0] SAC_ADDR_GAIN_LO = 8'hC1;
  localparam logic [7:0] SAC_ADDR_GAIN_HI = 8'hC2;
  localparam logic [7:0] SAC_ADDR_GT_LO   = 8'hC3;
  localparam logic [7:0] SAC_ADDR_GT_HI   = 8'hC4;
  localparam logic [7:0] SAC_ADDR_LT_LO   = 8'hC5;
  localparam logic [7:0] SAC_ADDR_LT_HI   = 8'hC6;
  localparam logic [7:0] SAC_ADDR_CTRL    = 8'hE8;
  localparam logic [7:0] SAC_SFR_BASE     = 8'h80;

  // control register bit positions
  localparam int SAC_CTRL_EN    = 7;
  localparam int SAC_CTRL_BURST = 6;
  localparam int SAC_CTRL_DONE  = 5;
  localparam int SAC_CTRL_BUSY  = 4;
  localparam int SAC_CTRL_WIN   = 3;
  localparam int SAC_CTRL_LJST  = 2;
  localparam int SAC_CTRL_CM_HI = 1;

  // configuration register: repeat count field position
  localparam int SAC_CFG_RPT_HI = 1;

  // start sources
  localparam logic [1:0] SAC_CM_SW   = 2'h0;
  localparam logic [1:0] SAC_CM_TMR1 = 2'h1;
  localparam logic [1:0] SAC_CM_EXT  = 2'h2;
  localparam logic [1:0] SAC_CM_TMR2 = 2'h3;

  // last sample index for repeat codes 1, 4, 8, 16
  localparam logic [3:0] SAC_LAST_R1  = 4'h0;
  localparam logic [3:0] SAC_LAST_R4  = 4'h3;
  localparam logic [3:0] SAC_LAST_R8  = 4'h7;
  localparam logic [3:0] SAC_LAST_R16 = 4'hF;

  // values after reset
  localparam logic [7:0] SAC_RST_BYTE    = 8'h00;
  localparam logic [7:0] SAC_RST_GAIN_LO = 8'h00;
  localparam logic [4:0] SAC_RST_GAIN_HI = 5'h10;
  localparam logic [7:0] SAC_RST_LT      = 8'h00;
  localparam logic [7:0] SAC_RST_GT      = 8'hFF;

  typedef enum logic {SAC_ST_IDLE, SAC_ST_RUN} sac_state_e;

endpackage

// *** design/sac_ctrl.sv ***
`timescale 1ns/1ps
module sac_ctrl #(
  parameter int CODE_W = 12
) (
  // clock, reset, freeze
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  // special register port
  input  wire logic [7:0]       sfr_addr,
  input  wire logic             sfr_wr_en,
  input  wire logic             sfr_rd_en,
  input  wire logic             sfr_bit_en,
  input  wire logic [2:0]       sfr_bit_idx,
  input  wire logic [7:0]       sfr_wdata,
  output logic      [7:0]       sfr_rdata,
  // start sources
  input  wire logic             tmr1_ovf,
  input  wire logic             tmr2_ovf,
  input  wire logic             ext_start_input,
  // converter core
  input  wire logic             sample_valid,
  input  wire logic [CODE_W-1:0] sample_code,
  output logic                  conv_start,
  output logic                  conv_power,
  // analog configuration
  output logic      [7:0]       analog_input_mux,
  output logic      [7:0]       track_cfg,
  output logic      [12:0]      gain_code,
  // flags
  output logic                  conv_done_flag,
  output logic                  window_match_flag
);
  import sac_pkg::*;

  localparam int ACC_W = CODE_W + 4;

  // ==========================================================
  // elaboration check
  generate
    if (CODE_W != 12) begin : g_bad_width
      $error("sac_ctrl supports only a 12-bit code");
    end
  endgenerate

  // ==========================================================
  // state
  sac_state_e        state_q, state_d;
  logic              en_q, burst_q, ljst_q;
  logic [1:0]        cm_q;
  logic              done_q, done_d, win_q, win_d;
  logic [7:0]        cfg_q, mux_q, trk_q;
  logic [7:0]        gtl_q, gth_q, ltl_q, lth_q, gain_lo_q;
  logic [4:0]        gain_hi_q;
  logic [ACC_W-1:0]  acc_q, acc_sum;
  logic [3:0]        cnt_q, last_idx;
  logic [15:0]       res_q, fmt;
  logic              start_q, power_q, ext_prev_q;
  logic [7:0]        rdata_q, rd_d;

  // ==========================================================
  // access decode
  logic       in_space, bit_ok, wr_ctrl, sw_start, trig, last_hit, win_hit;
  logic [7:0] ctrl_rd, ctrl_w;
  logic [15:0] gt_v, lt_v;

  assign in_space = sfr_addr >= SAC_SFR_BASE;
  assign bit_ok   = sfr_bit_en && in_space && (sfr_addr[2:0] == 3'h0);

  // live view of the control register
  assign ctrl_rd = {en_q, burst_q, done_q, (state_q == SAC_ST_RUN), win_q, ljst_q, cm_q};

  // byte write wins over bit write in the same cycle
  always_comb begin
    ctrl_w = ctrl_rd;
    if (sfr_wr_en) begin
      ctrl_w = sfr_wdata;
    end else begin
      ctrl_w[sfr_bit_idx] = sfr_wdata[0];
    end
  end

  assign wr_ctrl  = ce && (sfr_addr == SAC_ADDR_CTRL) && (sfr_wr_en || bit_ok);
  assign sw_start = wr_ctrl && ctrl_w[SAC_CTRL_BUSY] && !ctrl_rd[SAC_CTRL_BUSY];

  // ==========================================================
  // trigger selection
  always_comb begin
    unique case (cm_q)
      SAC_CM_SW:   trig = sw_start && (ctrl_w[SAC_CTRL_CM_HI:0] == SAC_CM_SW);
      SAC_CM_TMR1: trig = tmr1_ovf;
      SAC_CM_EXT:  trig = ext_start_input && !ext_prev_q;
      SAC_CM_TMR2: trig = tmr2_ovf;
    endcase
  end

  // repeat count decode
  always_comb begin
    unique case (cfg_q[SAC_CFG_RPT_HI:0])
      2'h0:    last_idx = SAC_LAST_R1;
      2'h1:    last_idx = SAC_LAST_R4;
      2'h2:    last_idx = SAC_LAST_R8;
      2'h3:    last_idx = SAC_LAST_R16;
    endcase
  end

  // ==========================================================
  // accumulation and formatting
  assign acc_sum  = acc_q + {{(ACC_W-CODE_W){1'b0}}, sample_code};
  assign fmt      = ljst_q ? {acc_sum[11:0], 4'h0} : acc_sum[15:0];
  assign last_hit = (state_q == SAC_ST_RUN) && sample_valid && (cnt_q == last_idx);
  assign gt_v     = {gth_q, gtl_q};
  assign lt_v     = {lth_q, ltl_q};
  assign win_hit  = (lt_v > gt_v) ? ((fmt > gt_v) && (fmt < lt_v))
                                  : ((fmt > gt_v) || (fmt < lt_v));

  // next state of the series
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SAC_ST_IDLE: if (en_q && trig) begin
        state_d = SAC_ST_RUN;
      end
      SAC_ST_RUN: if (!en_q || last_hit) begin
        state_d = SAC_ST_IDLE;
      end
    endcase
  end

  // sticky flags, hardware set wins over software clear
  always_comb begin
    done_d = wr_ctrl ? ctrl_w[SAC_CTRL_DONE] : done_q;
    win_d  = wr_ctrl ? ctrl_w[SAC_CTRL_WIN] : win_q;
    if (state_q == SAC_ST_RUN && state_d == SAC_ST_IDLE) begin
      done_d = 1'b1;
    end
    if (last_hit && en_q && win_hit) begin
      win_d = 1'b1;
    end
  end

  // ==========================================================
  // series sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= SAC_ST_IDLE;
      cnt_q   <= 4'h0;
      acc_q   <= '0;
      start_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      start_q <= 1'b0;
      if (state_q == SAC_ST_IDLE && state_d == SAC_ST_RUN) begin
        cnt_q   <= 4'h0;
        acc_q   <= '0;
        start_q <= 1'b1;
      end else if (state_q == SAC_ST_RUN && en_q && sample_valid && !last_hit) begin
        cnt_q   <= cnt_q + 4'h1;
        acc_q   <= acc_sum;
        start_q <= 1'b1;
      end
    end
  end

  // result latch at the end of a series only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      res_q <= 16'h0000;
    end else if (ce && last_hit && en_q) begin
      res_q <= fmt;
    end
  end

  // power: off when disabled, burst wakes only for the series
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      power_q <= 1'b0;
    end else if (ce) begin
      power_q <= en_q && (!burst_q || state_d == SAC_ST_RUN);
    end
  end

  // external start edge history
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_prev_q <= 1'b0;
    end else if (ce) begin
      ext_prev_q <= ext_start_input;
    end
  end

  // ==========================================================
  // control register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_q    <= 1'b0;
      burst_q <= 1'b0;
      ljst_q  <= 1'b0;
      cm_q    <= 2'h0;
      done_q  <= 1'b0;
      win_q   <= 1'b0;
    end else if (ce) begin
      done_q <= done_d;
      win_q  <= win_d;
      if (wr_ctrl) begin
        en_q    <= ctrl_w[SAC_CTRL_EN];
        burst_q <= ctrl_w[SAC_CTRL_BURST];
        ljst_q  <= ctrl_w[SAC_CTRL_LJST];
        cm_q    <= ctrl_w[SAC_CTRL_CM_HI:0];
      end
    end
  end

  // byte-only registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q     <= SAC_RST_BYTE;
      mux_q     <= SAC_RST_BYTE;
      trk_q     <= SAC_RST_BYTE;
      gtl_q     <= SAC_RST_GT;
      gth_q     <= SAC_RST_GT;
      ltl_q     <= SAC_RST_LT;
      lth_q     <= SAC_RST_LT;
      gain_lo_q <= SAC_RST_GAIN_LO;
      gain_hi_q <= SAC_RST_GAIN_HI;
    end else if (ce && sfr_wr_en) begin
      unique case (sfr_addr)
        SAC_ADDR_CFG:     cfg_q     <= sfr_wdata;
        SAC_ADDR_MUX:     mux_q     <= sfr_wdata;
        SAC_ADDR_TRACK:   trk_q     <= sfr_wdata;
        SAC_ADDR_GT_LO:   gtl_q     <= sfr_wdata;
        SAC_ADDR_GT_HI:   gth_q     <= sfr_wdata;
        SAC_ADDR_LT_LO:   ltl_q     <= sfr_wdata;
        SAC_ADDR_LT_HI:   lth_q     <= sfr_wdata;
        SAC_ADDR_GAIN_LO: gain_lo_q <= sfr_wdata;
        SAC_ADDR_GAIN_HI: gain_hi_q <= sfr_wdata[4:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // read path, unmapped addresses return zero
  always_comb begin
    rd_d = 8'h00;
    unique case (sfr_addr)
      SAC_ADDR_CTRL:    rd_d = ctrl_rd;
      SAC_ADDR_CFG:     rd_d = cfg_q;
      SAC_ADDR_MUX:     rd_d = mux_q;
      SAC_ADDR_TRACK:   rd_d = trk_q;
      SAC_ADDR_RES_LO:  rd_d = res_q[7:0];
      SAC_ADDR_RES_HI:  rd_d = res_q[15:8];
      SAC_ADDR_GT_LO:   rd_d = gtl_q;
      SAC_ADDR_GT_HI:   rd_d = gth_q;
      SAC_ADDR_LT_LO:   rd_d = ltl_q;
      SAC_ADDR_LT_HI:   rd_d = lth_q;
      SAC_ADDR_GAIN_LO: rd_d = gain_lo_q;
      SAC_ADDR_GAIN_HI: rd_d = {3'h0, gain_hi_q};
      default:          rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else if (ce && sfr_rd_en) begin
      rdata_q <= rd_d;
    end
  end

  // output drive
  assign sfr_rdata         = rdata_q;
  assign conv_start        = start_q;
  assign conv_power        = power_q;
  assign analog_input_mux  = mux_q;
  assign track_cfg         = trk_q;
  assign gain_code         = {gain_hi_q, gain_lo_q};
  assign conv_done_flag    = done_q;
  assign window_match_flag = win_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_final_sample;
    ce && (state_q == SAC_ST_RUN) && en_q && sample_valid && (cnt_q == last_idx);
  endsequence

  sequence s_single_take;
    s_final_sample ##0 (cfg_q[1:0] == 2'h0);
  endsequence

  a_done_on_fall: assert property ($fell(state_q == SAC_ST_RUN) |-> done_q)
    else $error("done flag not set at end of series");

  a_single_update: assert property (s_single_take ##0 !ljst_q
      |=> (res_q == {4'h0, $past(sample_code)}) && state_q == SAC_ST_IDLE)
    else $error("single result not latched right-justified");

  a_left_layout: assert property (s_single_take ##0 ljst_q
      |=> res_q == {$past(sample_code), 4'h0})
    else $error("left-justified layout wrong");

  a_accum_hold: assert property ((state_q == SAC_ST_RUN) && $past(state_q == SAC_ST_RUN)
      |-> $stable(res_q))
    else $error("result changed mid-series");

  a_no_conv_off: assert property (ce && !en_q |=> !conv_start && !conv_power)
    else $error("converter active while disabled");

  a_burst_sleep: assert property (ce && en_q && burst_q && state_q == SAC_ST_IDLE && !trig
      |=> !conv_power)
    else $error("burst mode left converter powered");

  a_sw_start: assert property (ce && en_q && cm_q == SAC_CM_SW && sfr_wr_en
      && sfr_addr == SAC_ADDR_CTRL && sfr_wdata == 8'h90 && state_q == SAC_ST_IDLE
      |=> ctrl_rd[SAC_CTRL_BUSY] ##0 conv_start)
    else $error("software start not taken");

  a_win_sticky: assert property (win_q && !wr_ctrl |=> win_q)
    else $error("window flag cleared by hardware");

  a_bit_refused: assert property (ce && sfr_bit_en && !sfr_wr_en && sfr_addr == SAC_ADDR_CFG
      |=> $stable(cfg_q))
    else $error("bit write reached byte-only register");

  a_ctrl_read: assert property (ce && sfr_rd_en && sfr_addr == SAC_ADDR_CTRL
      |=> sfr_rdata == $past(ctrl_rd))
    else $error("control read mismatch");

endmodule // sac_ctrl

// *** testbench/sar_adc_control_result_format_tb_top.sv ***
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for converter control and result layout
module sar_adc_control_result_format_tb_top;
  import sac_pkg::*;

  logic        clk, rstn, ce, wr_en, rd_en, bit_en;
  logic        tmr1, tmr2, ext, svalid, cstart, cpower, done, win;
  logic [7:0]  addr, wdata, rdata, mux, trk;
  logic [2:0]  bidx;
  logic [11:0] code;
  logic [12:0] gain;
  logic [15:0] prev;
  int          miscompares;
  int          comparisons;

  sac_ctrl #(.CODE_W(12)) dut (
    .clk(clk), .rstn(rstn), .ce(ce), .sfr_addr(addr), .sfr_wr_en(wr_en),
    .sfr_rd_en(rd_en), .sfr_bit_en(bit_en), .sfr_bit_idx(bidx), .sfr_wdata(wdata),
    .sfr_rdata(rdata), .tmr1_ovf(tmr1), .tmr2_ovf(tmr2), .ext_start_input(ext),
    .sample_valid(svalid), .sample_code(code), .conv_start(cstart),
    .conv_power(cpower), .analog_input_mux(mux), .track_cfg(trk), .gain_code(gain),
    .conv_done_flag(done), .window_match_flag(win));

  // 50 ns system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==========================================================
  // checking and closing
  task automatic give_verdict();
    $display("counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk_bit(input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // ==========================================================
  // register access, one idle edge first; b selects a bit write, index d[6:4], value d[0]
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit b = 1'b0);
    @(posedge clk);
    #5;
    addr = a;
    wdata = d;
    bidx = d[6:4];
    wr_en = !b;
    bit_en = b;
    @(posedge clk);
    #5;
    wr_en = 1'b0;
    bit_en = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #5;
    addr = a;
    rd_en = 1'b1;
    @(posedge clk);
    #5;
    rd_en = 1'b0;
    d = rdata;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk_val({8'h00, e}, {8'h00, d});
  endtask

  // ==========================================================
  // conversion helpers
  task automatic wait_start();
    for (int k = 0; k < 16 && cstart !== 1'b1; k++) begin
      @(posedge clk);
      #5;
    end
    chk_bit(1'b1, cstart);
    if (cstart !== 1'b1) give_verdict();
  endtask

  task automatic no_start();
    repeat (4) begin
      chk_bit(1'b0, cstart);
      @(posedge clk);
      #5;
    end
  endtask

  task automatic trig(input logic [1:0] cm);
    tmr1 = (cm == SAC_CM_TMR1);
    ext = (cm == SAC_CM_EXT);
    tmr2 = (cm == SAC_CM_TMR2);
    @(posedge clk);
    #5;
    {tmr1, ext, tmr2} = 3'h0;
  endtask

  // one series: start, feed samples, check layout of the sum
  task automatic conv(input logic [1:0] rpt, input logic lj, input logic [1:0] cm,
                      input logic [11:0] fix, input bit rnd);
    int n;
    logic [15:0] sum;
    logic [7:0] d;
    logic [7:0] hi;
    n = (rpt == 2'h0) ? 1 : (2 << rpt);
    sum = 16'h0000;
    if (cm == SAC_CM_SW) begin
      wr(SAC_ADDR_CTRL, {5'h10, lj, 2'h0});
      wr(SAC_ADDR_CTRL, {5'h12, lj, 2'h0});
    end else begin
      trig(cm);
    end
    for (int i = 0; i < n; i++) begin
      wait_start();
      if (i == 0) begin
        rd(SAC_ADDR_CTRL, d);
        chk_bit(1'b1, d[SAC_CTRL_BUSY]);
      end else begin
        rd(SAC_ADDR_RES_LO, d);
        chk_val({8'h00, prev[7:0]}, {8'h00, d});
      end
      code = rnd ? 12'($urandom) : fix;
      sum = sum + 16'(code);
      svalid = 1'b1;
      @(posedge clk);
      #5;
      svalid = 1'b0;
    end
    chk_bit(1'b1, done);
    prev = lj ? {sum[11:0], 4'h0} : sum;
    rd(SAC_ADDR_RES_HI, hi);
    rd(SAC_ADDR_RES_LO, d);
    chk_val(prev, {hi, d});
    rd(SAC_ADDR_CTRL, d);
    chk_bit(1'b0, d[SAC_CTRL_BUSY]);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    int r;
    logic [7:0] d;
    logic [7:0] g;
    {rstn, ce, wr_en, rd_en, bit_en, tmr1, tmr2, ext, svalid} = 9'h080;
    {addr, wdata, bidx, code} = '0;
    miscompares = 0;
    comparisons = 0;
    prev = 16'h0000;
    r = $urandom(32'h041D);
    repeat (6) @(posedge clk);
    #5;
    rstn = 1'b1;
    // reset state, decode range, read-only result
    chk_val(16'h1000, {3'h0, gain});
    wr(8'h68, 8'h80);
    wr(SAC_ADDR_RES_HI, 8'hFF);
    rc(SAC_ADDR_CTRL, 8'h00);
    rc(SAC_ADDR_RES_HI, 8'h00);
    rc(SAC_ADDR_GT_HI, 8'hFF);
    chk_bit(1'b0, cpower);
    $display("test reset done");
    // disabled, software start in timer mode, burst power
    wr(SAC_ADDR_CTRL, 8'h01);
    trig(SAC_CM_TMR1);
    no_start();
    wr(SAC_ADDR_CTRL, 8'h91);
    no_start();
    chk_bit(1'b1, cpower);
    wr(SAC_ADDR_CTRL, 8'hC3);
    @(posedge clk);
    #5;
    chk_bit(1'b0, cpower);
    conv(2'h0, 1'b0, SAC_CM_TMR2, 12'h123, 1'b0);
    chk_bit(1'b0, cpower);
    $display("test enable done");
    // single samples, corner and random codes, both layouts
    wr(SAC_ADDR_CFG, 8'h00);
    conv(2'h0, 1'b0, SAC_CM_SW, 12'hFFF, 1'b0);
    conv(2'h0, 1'b1, SAC_CM_SW, 12'hFFF, 1'b0);
    conv(2'h0, 1'b0, SAC_CM_SW, 12'h800, 1'b0);
    conv(2'h0, 1'b1, SAC_CM_SW, 12'h7FF, 1'b0);
    repeat (6) conv(2'h0, 1'($urandom), SAC_CM_SW, 12'h000, 1'b1);
    $display("test single done");
    // accumulation of 4, 8 and 16, right justified only
    for (int k = 1; k < 4; k++) begin
      wr(SAC_ADDR_CFG, 8'(k));
      conv(2'(k), 1'b0, SAC_CM_SW, 12'h000, 1'b1);
      conv(2'(k), 1'b0, SAC_CM_SW, 12'hFFF, 1'b0);
    end
    $display("test accumulate done");
    // every hardware start source
    wr(SAC_ADDR_CFG, 8'h00);
    for (int m = 1; m < 4; m++) begin
      wr(SAC_ADDR_CTRL, 8'(128 + m));
      conv(2'h0, 1'b0, 2'(m), 12'h000, 1'b1);
    end
    $display("test sources done");
    // window flag, sticky until cleared by bit writes
    wr(SAC_ADDR_CTRL, 8'h81);
    conv(2'h0, 1'b0, SAC_CM_TMR1, 12'h800, 1'b0);
    chk_bit(1'b0, win);
    wr(SAC_ADDR_GT_HI, 8'h01);
    wr(SAC_ADDR_GT_LO, 8'h00);
    conv(2'h0, 1'b0, SAC_CM_TMR1, 12'hFFF, 1'b0);
    chk_bit(1'b1, win);
    conv(2'h0, 1'b0, SAC_CM_TMR1, 12'h050, 1'b0);
    chk_bit(1'b1, win);
    wr(SAC_ADDR_CTRL, 8'h30, 1'b1);
    chk_bit(1'b0, win);
    wr(SAC_ADDR_CTRL, 8'h50, 1'b1);
    chk_bit(1'b0, done);
    wr(SAC_ADDR_CFG, 8'h01, 1'b1);
    rc(SAC_ADDR_CFG, 8'h00);
    $display("test window done");
    // analog configuration and gain registers
    repeat (3) begin
      d = 8'($urandom);
      g = 8'($urandom);
      wr(SAC_ADDR_MUX, d);
      wr(SAC_ADDR_TRACK, g);
      wr(SAC_ADDR_GAIN_LO, g);
      wr(SAC_ADDR_GAIN_HI, d);
      chk_val({d, g}, {mux, trk});
      chk_val({3'h0, d[4:0], g}, {3'h0, gain});
      rc(SAC_ADDR_GAIN_HI, {3'h0, d[4:0]});
    end
    $display("test gain done");
    // frozen clock enable: write and trigger both ignored
    ce = 1'b0;
    wr(SAC_ADDR_MUX, ~d);
    trig(SAC_CM_TMR1);
    no_start();
    chk_val({8'h00, d}, {8'h00, mux});
    ce = 1'b1;
    $display("test freeze done");
    give_verdict();
  end
endmodule // sar_adc_control_result_format_tb_top
